// file: include/cts_consts.svh
// Constants of the charge thermal supervisor: offsets, fields, resets, timing.
// Included by the design, the checker and the bench; definitions only.
`ifndef CTS_CONSTS_SVH
`define CTS_CONSTS_SVH

`define CTS_OFF_CTRL        12'h000
`define CTS_OFF_CURRENT     12'h004
`define CTS_OFF_VOLTAGE     12'h008
`define CTS_OFF_CNFG7       12'h00c
`define CTS_OFF_STATUS      12'h010
`define CTS_OFF_EVENT       12'h014

`define CTS_CTRL_RST        32'h0000_0001
`define CTS_CUR_RST         32'h0000_0000
`define CTS_VOLT_RST        32'h0000_0000
`define CTS_CNFG7_RST       32'h0000_0000

// Control register bits
`define CTS_BIT_PROFILE_EN  0
`define CTS_BIT_VARIANT_B   1
`define CTS_BIT_DEB_SEL     2
`define CTS_BIT_CHG_EN      3
// Config seven bits
`define CTS_BIT_SHIP_REQ    0
`define CTS_BIT_SWDRV_EN    1
`define CTS_POS_OVC_TH      4
// Mode field in control
`define CTS_POS_MODE        8
`define CTS_MODE_BOOST      4'h9
`define CTS_MODE_BOOST_OTG  4'ha

// Charge detail codes
`define CTS_DTL_OFF         4'h8
`define CTS_DTL_CHARGING    4'h2
`define CTS_DTL_TEMP_SUSP   4'h5
`define CTS_DTL_NO_BATT     4'h6
// Thermistor detail codes
`define CTS_THM_COLD        3'h1
`define CTS_THM_COOL        3'h2
`define CTS_THM_NORMAL      3'h3
`define CTS_THM_WARM        3'h4
`define CTS_THM_HOT         3'h5
`define CTS_THM_REMOVED     3'h6
`define CTS_THM_GROUNDED    3'h7
`define CTS_THM_DISABLED    3'h0

// Termination voltage step is 12.5 mV per code
`define CTS_WARM_DROP_A     8'd15
`define CTS_WARM_DROP_B     8'd30

// Ship-exit debounce times and cycle counts at 50 MHz
`define CTS_CLK_MHZ         50
`define CTS_DEB_SHORT_US    100
`define CTS_DEB_LONG_US     8000
`define CTS_DEB_SHORT_CYC   (`CTS_DEB_SHORT_US * `CTS_CLK_MHZ)
`define CTS_DEB_LONG_CYC    (`CTS_DEB_LONG_US * `CTS_CLK_MHZ)

`endif

// file: include/cts_pkg.sv
// Types of the charge thermal supervisor.
// Needs nothing outside itself.
package cts_pkg;

    typedef enum logic [6:0] {
        CTS_COLD    = 7'b0000001,
        CTS_COOL    = 7'b0000010,
        CTS_NORMAL  = 7'b0000100,
        CTS_WARM    = 7'b0001000,
        CTS_HOT     = 7'b0010000,
        CTS_REMOVED = 7'b0100000,
        CTS_GROUND  = 7'b1000000
    } cts_zone_type;

    typedef enum logic [2:0] {
        CTS_ST_IDLE   = 3'b001,
        CTS_ST_CHARGE = 3'b010,
        CTS_ST_SUSP   = 3'b100
    } cts_chg_type;

    // Analog comparator bundle
    typedef struct packed {
        logic cold;
        logic cool;
        logic warm;
        logic hot;
        logic pulledUp;
        logic grounded;
    } cts_comp_type;

endpackage

// file: logic/cts_supervisor.sv
// Charge thermal supervisor: zones, foldback, ship mode, switch drive.
// Assumes an APB master on core_clk, comparator levels from analog circuitry.
`timescale 1ns/1ps
`include "cts_consts.svh"

module cts_supervisor
    import cts_pkg::*;
#(
    parameter int DEB_SHORT_CYC = `CTS_DEB_SHORT_CYC,
    parameter int DEB_LONG_CYC  = `CTS_DEB_LONG_CYC,
    parameter int FOLD_STEP     = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire cts_comp_type compAsync,
    input  wire logic         dieOverSetpoint,
    input  wire logic         chargerInputValid,
    input  wire logic         buckSwitching,
    input  wire logic         shipExitPushbutton,
    output logic              chargeEnable,
    output logic [7:0]        targetCurrent,
    output logic [7:0]        targetVoltage,
    output logic              safetyTimerDouble,
    output logic              chargeTimerRestart,
    output logic              shipModeActive,
    output logic              externalSwitchDriveOut,
    output logic              externalSwitchDriveOe,
    output logic              chargerEventIrq
);

    localparam int DCW = $clog2(DEB_LONG_CYC + 1);

    logic [31:0]  ctrl_r, cur_r, volt_r, cnfg7_r;
    cts_comp_type compMeta_r, compSync_r;
    logic         foldSync1_r, foldSync2_r;
    cts_zone_type zone_r, zone_nxt;
    cts_chg_type  state_r, state_nxt;
    logic         fold_r;
    logic [3:0]   chgDetail_r, chgDetail_nxt;
    logic [2:0]   thmDetail_r, thmDetail_nxt;
    logic         healthy_r;
    logic         eventSticky_r;
    logic [DCW-1:0] debCnt_r;
    logic         shipReqWr;
    logic         eventClr;
    logic         eventSet;
    logic         nonBattery;
    logic         profileOn;
    logic         inRange;
    logic         battPresent;
    logic [7:0]   curSel, voltSel, dropSel;
    logic [DCW-1:0] debLimit;

    // APB decode, zero-wait answer
    wire apbWr = psel && penable && pwrite;
    wire apbRd = psel && penable && !pwrite;
    // Answer flags held in flops, always ready, never an error
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
    end
    assign shipReqWr = apbWr && paddr == `CTS_OFF_CNFG7
                       && pwdata[`CTS_BIT_SHIP_REQ];
    assign eventClr  = apbRd && paddr == `CTS_OFF_EVENT;

    // Register writes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r  <= `CTS_CTRL_RST;
            cur_r   <= `CTS_CUR_RST;
            volt_r  <= `CTS_VOLT_RST;
            cnfg7_r <= `CTS_CNFG7_RST;
        end else if (apbWr) begin
            case (paddr)
                `CTS_OFF_CTRL:    ctrl_r  <= pwdata;
                `CTS_OFF_CURRENT: cur_r   <= pwdata;
                `CTS_OFF_VOLTAGE: volt_r  <= pwdata;
                `CTS_OFF_CNFG7: begin
                    // Request bit self-clears; ship state lives apart
                    cnfg7_r <= {pwdata[31:1], 1'b0};
                end
                default: ;
            endcase
        end
    end

    // Read mux, registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `CTS_OFF_CTRL:    prdata <= ctrl_r;
                `CTS_OFF_CURRENT: prdata <= cur_r;
                `CTS_OFF_VOLTAGE: prdata <= volt_r;
                `CTS_OFF_CNFG7:   prdata <= {cnfg7_r[31:1], shipModeActive};
                `CTS_OFF_STATUS:  prdata <= {22'h00_0000, fold_r, healthy_r,
                                             1'b0, thmDetail_r,
                                             chgDetail_r};
                `CTS_OFF_EVENT:   prdata <= {31'h0000_0000, eventSticky_r};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Two-flop synchronisers for comparators and foldback
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            compMeta_r  <= '0;
            compSync_r  <= '0;
            foldSync1_r <= 1'b0;
            foldSync2_r <= 1'b0;
        end else begin
            compMeta_r  <= compAsync;
            compSync_r  <= compMeta_r;
            foldSync1_r <= dieOverSetpoint;
            foldSync2_r <= foldSync1_r;
        end
    end

    // Zone encoding, rail and ground first
    always_comb begin
        if (compSync_r.pulledUp)      zone_nxt = CTS_REMOVED;
        else if (compSync_r.grounded) zone_nxt = CTS_GROUND;
        else if (compSync_r.cold)     zone_nxt = CTS_COLD;
        else if (compSync_r.hot)      zone_nxt = CTS_HOT;
        else if (compSync_r.cool)     zone_nxt = CTS_COOL;
        else if (compSync_r.warm)     zone_nxt = CTS_WARM;
        else                          zone_nxt = CTS_NORMAL;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) zone_r <= CTS_NORMAL;
        else        zone_r <= zone_nxt;
    end

    // Qualification terms
    assign profileOn   = ctrl_r[`CTS_BIT_PROFILE_EN]
                         && zone_r != CTS_GROUND;
    assign battPresent = zone_r != CTS_REMOVED;
    assign inRange     = !profileOn ||
                         (zone_r != CTS_COLD && zone_r != CTS_HOT);

    // Charge state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CTS_ST_IDLE: begin
                if (chargerInputValid && battPresent && !shipModeActive
                    && ctrl_r[`CTS_BIT_CHG_EN])
                    state_nxt = inRange ? CTS_ST_CHARGE : CTS_ST_SUSP;
            end
            CTS_ST_CHARGE: begin
                if (!chargerInputValid || !battPresent
                    || !ctrl_r[`CTS_BIT_CHG_EN])
                    state_nxt = CTS_ST_IDLE;
                else if (!inRange)
                    state_nxt = CTS_ST_SUSP;
            end
            CTS_ST_SUSP: begin
                if (!chargerInputValid || !battPresent
                    || !ctrl_r[`CTS_BIT_CHG_EN])
                    state_nxt = CTS_ST_IDLE;
                else if (inRange)
                    state_nxt = CTS_ST_CHARGE;
            end
            default: state_nxt = CTS_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) state_r <= CTS_ST_IDLE;
        else        state_r <= state_nxt;
    end

    // Detail fields; healthy flag only from charge detail
    always_comb begin
        case (state_r)
            CTS_ST_CHARGE: chgDetail_nxt = `CTS_DTL_CHARGING;
            CTS_ST_SUSP:   chgDetail_nxt = `CTS_DTL_TEMP_SUSP;
            default:       chgDetail_nxt = battPresent ? `CTS_DTL_OFF
                                                       : `CTS_DTL_NO_BATT;
        endcase
        if (!ctrl_r[`CTS_BIT_PROFILE_EN]) thmDetail_nxt = `CTS_THM_DISABLED;
        else begin
            case (zone_r)
                CTS_COLD:    thmDetail_nxt = `CTS_THM_COLD;
                CTS_COOL:    thmDetail_nxt = `CTS_THM_COOL;
                CTS_WARM:    thmDetail_nxt = `CTS_THM_WARM;
                CTS_HOT:     thmDetail_nxt = `CTS_THM_HOT;
                CTS_REMOVED: thmDetail_nxt = `CTS_THM_REMOVED;
                CTS_GROUND:  thmDetail_nxt = `CTS_THM_GROUNDED;
                default:     thmDetail_nxt = `CTS_THM_NORMAL;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chgDetail_r <= `CTS_DTL_OFF;
            thmDetail_r <= `CTS_THM_DISABLED;
            healthy_r   <= 1'b1;
        end else begin
            chgDetail_r <= chgDetail_nxt;
            thmDetail_r <= thmDetail_nxt;
            healthy_r   <= chgDetail_nxt != `CTS_DTL_TEMP_SUSP;
        end
    end

    // Foldback loop state and charger event, set beats clear
    assign eventSet = (foldSync2_r != fold_r)
                      || (state_r != CTS_ST_SUSP
                          && state_nxt == CTS_ST_SUSP);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fold_r        <= 1'b0;
            eventSticky_r <= 1'b0;
        end else begin
            fold_r <= foldSync2_r;
            if (eventSet)      eventSticky_r <= 1'b1;
            else if (eventClr) eventSticky_r <= 1'b0;
        end
    end

    // Current and voltage selection per zone
    assign dropSel = ctrl_r[`CTS_BIT_VARIANT_B] ? `CTS_WARM_DROP_B
                                                : `CTS_WARM_DROP_A;
    always_comb begin
        curSel  = cur_r[7:0];
        voltSel = volt_r[7:0];
        if (profileOn && zone_r == CTS_WARM) begin
            curSel  = cur_r[15:8];
            voltSel = volt_r[7:0] - dropSel;
        end else if (profileOn && zone_r == CTS_COOL) begin
            curSel  = {1'b0, cur_r[7:1]};
            voltSel = volt_r[15:8];
        end
        if (fold_r)
            curSel = (curSel > 8'(FOLD_STEP)) ? curSel - 8'(FOLD_STEP)
                                              : 8'h00;
    end

    // Charger outputs, timer restart on entering charge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chargeEnable       <= 1'b0;
            targetCurrent      <= 8'h00;
            targetVoltage      <= 8'h00;
            safetyTimerDouble  <= 1'b0;
            chargeTimerRestart <= 1'b0;
            chargerEventIrq    <= 1'b0;
        end else begin
            chargeEnable  <= state_nxt == CTS_ST_CHARGE;
            targetCurrent <= curSel;
            targetVoltage <= voltSel;
            safetyTimerDouble <= profileOn && zone_r == CTS_COOL;
            chargeTimerRestart <= state_r != CTS_ST_CHARGE
                                  && state_nxt == CTS_ST_CHARGE;
            chargerEventIrq <= eventSticky_r || eventSet;
        end
    end

    // Ship-exit pushbutton debounce
    assign debLimit = ctrl_r[`CTS_BIT_DEB_SEL] ? DCW'(DEB_LONG_CYC)
                                               : DCW'(DEB_SHORT_CYC);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)                  debCnt_r <= '0;
        else if (!shipExitPushbutton || !shipModeActive) debCnt_r <= '0;
        else if (debCnt_r < debLimit) debCnt_r <= debCnt_r + DCW'(1);
    end

    // Ship mode entry and exit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shipModeActive <= 1'b0;
        end else if (shipModeActive) begin
            if (!battPresent || chargerInputValid
                || debCnt_r >= debLimit)
                shipModeActive <= 1'b0;
        end else if (shipReqWr && !chargerInputValid) begin
            shipModeActive <= 1'b1;
        end
    end

    // Switch drive: battery mode pulls low when enabled
    assign nonBattery = (chargerInputValid && buckSwitching)
        || ctrl_r[`CTS_POS_MODE +: 4] == `CTS_MODE_BOOST
        || ctrl_r[`CTS_POS_MODE +: 4] == `CTS_MODE_BOOST_OTG;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            externalSwitchDriveOut <= 1'b0;
            externalSwitchDriveOe  <= 1'b0;
        end else begin
            externalSwitchDriveOut <= 1'b0;
            externalSwitchDriveOe  <= cnfg7_r[`CTS_BIT_SWDRV_EN]
                                      && !nonBattery;
        end
    end

endmodule

// file: tb/cts_therm_model.sv
// Battery thermistor model: zone select to comparator levels.
// Levels change only after a clock edge, driven by the bench.
`timescale 1ns/1ps
module cts_therm_model
    import cts_pkg::*;
(
    input  wire logic [2:0] tempSel,
    output cts_comp_type    comp
);
    // Cumulative comparators; an open pin reads as very cold, a short as hot
    always_comb begin
        comp          = '0;
        comp.cold     = (tempSel == 3'h0) || (tempSel == 3'h5);
        comp.cool     = (tempSel <= 3'h1) || (tempSel == 3'h5);
        comp.warm     = (tempSel == 3'h3) || (tempSel == 3'h4);
        comp.hot      = (tempSel == 3'h4) || (tempSel == 3'h6);
        comp.pulledUp = (tempSel == 3'h5);
        comp.grounded = (tempSel == 3'h6);
    end
endmodule

// file: tb/cts_supervisor_sva.sv
// Port checker for the charge thermal supervisor.
// Bound to every cts_supervisor; sees its ports only.
`timescale 1ns/1ps
`include "cts_consts.svh"
module cts_supervisor_sva
    import cts_pkg::*;
#(
    parameter int DEB_SHORT_CYC = 4,
    parameter int DEB_LONG_CYC  = 10,
    parameter int FOLD_STEP     = 8
) (
    input wire logic         core_clk,
    input wire logic         rst_n,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    input wire logic         pready,
    input wire cts_comp_type compAsync,
    input wire logic         dieOverSetpoint,
    input wire logic         chargerInputValid,
    input wire logic         buckSwitching,
    input wire logic         shipExitPushbutton,
    input wire logic         chargeEnable,
    input wire logic         safetyTimerDouble,
    input wire logic         chargeTimerRestart,
    input wire logic         shipModeActive,
    input wire logic         externalSwitchDriveOut,
    input wire logic         externalSwitchDriveOe,
    input wire logic         chargerEventIrq
);
    logic profEn_r;
    int   btnCnt_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Profile enable mirrored from bus writes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            profEn_r <= 1'b1;
        else if (psel && penable && pwrite && pready
                 && paddr == `CTS_OFF_CTRL)
            profEn_r <= pwdata[`CTS_BIT_PROFILE_EN];
    end

    // Length of the present button press
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            btnCnt_r <= 0;
        else
            btnCnt_r <= shipExitPushbutton ? btnCnt_r + 1 : 0;
    end

    sequence s_cold_held;
        (compAsync.cold && !compAsync.pulledUp && !compAsync.grounded
         && profEn_r) [*6];
    endsequence
    sequence s_cool_held;
        (compAsync.cool && !compAsync.cold && !compAsync.hot
         && !compAsync.pulledUp && !compAsync.grounded && profEn_r) [*6];
    endsequence
    sequence s_fold_settled;
        $changed(dieOverSetpoint) ##1 $stable(dieOverSetpoint) [*4];
    endsequence

    property p_drive_low;
        externalSwitchDriveOut == 1'b0;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("switch drive output not low");
    property p_non_batt;
        (chargerInputValid && buckSwitching) [*2] |-> !externalSwitchDriveOe;
    endproperty
    a_non_batt: assert property (p_non_batt)
        else $error("switch drive held while adapter switching");
    property p_ship_refuse;
        chargerInputValid [*2] |-> !shipModeActive;
    endproperty
    a_ship_refuse: assert property (p_ship_refuse)
        else $error("ship mode with charger present");
    property p_ship_button;
        btnCnt_r > DEB_LONG_CYC + 4 |-> !shipModeActive;
    endproperty
    a_ship_button: assert property (p_ship_button)
        else $error("ship mode kept after long press");
    property p_cold_stop;
        s_cold_held |-> !chargeEnable;
    endproperty
    a_cold_stop: assert property (p_cold_stop)
        else $error("charging while too cold");
    property p_cool_double;
        s_cool_held |-> safetyTimerDouble;
    endproperty
    a_cool_double: assert property (p_cool_double)
        else $error("timer not doubled in cool zone");
    property p_fold_event;
        s_fold_settled |-> ##[0:3] chargerEventIrq;
    endproperty
    a_fold_event: assert property (p_fold_event)
        else $error("no event on foldback change");
    property p_restart_entry;
        $rose(chargeEnable) |->
            $past(chargeTimerRestart) or ##[0:1] chargeTimerRestart;
    endproperty
    a_restart_entry: assert property (p_restart_entry)
        else $error("charging began without timer restart");
endmodule

bind cts_supervisor cts_supervisor_sva #(.DEB_SHORT_CYC(DEB_SHORT_CYC),
    .DEB_LONG_CYC(DEB_LONG_CYC), .FOLD_STEP(FOLD_STEP)) chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .compAsync(compAsync), .dieOverSetpoint(dieOverSetpoint),
    .chargerInputValid(chargerInputValid), .buckSwitching(buckSwitching),
    .shipExitPushbutton(shipExitPushbutton), .chargeEnable(chargeEnable),
    .safetyTimerDouble(safetyTimerDouble),
    .chargeTimerRestart(chargeTimerRestart),
    .shipModeActive(shipModeActive),
    .externalSwitchDriveOut(externalSwitchDriveOut),
    .externalSwitchDriveOe(externalSwitchDriveOe),
    .chargerEventIrq(chargerEventIrq));

// file: tb/charge_thermal_supervisor_test.sv
// Bench for the charge thermal supervisor, one task per scenario.
// Assumes package, design, thermistor model and checker compiled first.
`timescale 1ns/1ps
`include "cts_consts.svh"
module charge_thermal_supervisor_test
    import cts_pkg::*;
;
    localparam logic [7:0] CUR = 8'h40, WCUR = 8'h20, FOLD = 8'h08;
    localparam logic [7:0] PRM = 8'h60, CVC = 8'h50;
    localparam logic [7:0] WVA = PRM - `CTS_WARM_DROP_A;
    localparam logic [7:0] WVB = PRM - `CTS_WARM_DROP_B;
    logic         core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, q;
    logic         die, chgValid, buck, button, chgEn, tDbl, restart;
    logic         ship, swOut, swOe, irq;
    logic [7:0]   cur, volt;
    logic [2:0]   tempSel;
    cts_comp_type comp;
    int           n_fail, checks, nRestart;

    // Clock and restart pulse counter
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (restart === 1'b1)
            nRestart++;
    end

    cts_therm_model therm_u (.tempSel(tempSel), .comp(comp));
    cts_supervisor #(.DEB_SHORT_CYC(4), .DEB_LONG_CYC(10)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .compAsync(comp),
        .dieOverSetpoint(die), .chargerInputValid(chgValid),
        .buckSwitching(buck), .shipExitPushbutton(button),
        .chargeEnable(chgEn), .targetCurrent(cur), .targetVoltage(volt),
        .safetyTimerDouble(tDbl), .chargeTimerRestart(restart),
        .shipModeActive(ship), .externalSwitchDriveOut(swOut),
        .externalSwitchDriveOe(swOe), .chargerEventIrq(irq));

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One transfer held until pready, then two idle cycles
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        cyc(2);
    endtask
    task automatic stat(input logic [3:0] d, input logic [2:0] t);
        apb(1'b0, `CTS_OFF_STATUS, 32'h0);
        chk({q[6:4], q[3:0]}, {t, d});
    endtask
    task automatic zone(input logic [2:0] s);
        tempSel <= s;
        cyc(6);
    endtask
    task automatic push(input int n);
        button <= 1'b1;
        cyc(n);
        button <= 1'b0;
        cyc(3);
    endtask

    task automatic t_regs();
        apb(1'b0, `CTS_OFF_CTRL, 32'h0);
        chk(q, `CTS_CTRL_RST);
        apb(1'b0, `CTS_OFF_CNFG7, 32'h0);
        chk(q, `CTS_CNFG7_RST);
        apb(1'b1, 12'h020, 32'hffff_ffff);
        apb(1'b0, 12'h020, 32'h0);
        chk(q, 32'h0);
        chk({pready, pslverr}, 2'b10);
    endtask
    task automatic t_zones();
        logic [2:0] t;
        apb(1'b1, `CTS_OFF_CURRENT, {16'h0, WCUR, CUR});
        apb(1'b1, `CTS_OFF_VOLTAGE, {16'h0, CVC, PRM});
        apb(1'b1, `CTS_OFF_CTRL, 32'h9);
        zone(3'h2);
        chk({chgEn, cur, volt}, {1'b1, CUR, PRM});
        stat(`CTS_DTL_CHARGING, `CTS_THM_NORMAL);
        zone(3'h1);
        chk({cur, volt, tDbl}, {CUR >> 1, CVC, 1'b1});
        stat(`CTS_DTL_CHARGING, `CTS_THM_COOL);
        zone(3'h3);
        chk({cur, volt, tDbl}, {WCUR, WVA, 1'b0});
        apb(1'b1, `CTS_OFF_CTRL, 32'hb);
        chk(volt, WVB);
        for (int i = 0; i < 2; i++) begin
            t = i ? `CTS_THM_HOT : `CTS_THM_COLD;
            apb(1'b0, `CTS_OFF_EVENT, 32'h0);
            zone(i ? 3'h4 : 3'h0);
            chk({chgEn, irq}, 2'b01);
            stat(`CTS_DTL_TEMP_SUSP, t);
            chk(q[8], 1'b0);
            apb(1'b0, `CTS_OFF_EVENT, 32'h0);
            chk(q[0], 1'b1);
            nRestart = 0;
            zone(3'h2);
            chk({chgEn, nRestart[1:0]}, 3'b101);
        end
    endtask
    task automatic t_prof_off();
        apb(1'b1, `CTS_OFF_CTRL, 32'h8);
        zone(3'h4);
        chk({chgEn, cur, volt}, {1'b1, CUR, PRM});
        stat(`CTS_DTL_CHARGING, `CTS_THM_DISABLED);
        zone(3'h1);
        chk({cur, tDbl}, {CUR, 1'b0});
    endtask
    task automatic t_batt();
        apb(1'b1, `CTS_OFF_CTRL, 32'h9);
        zone(3'h5);
        chk(chgEn, 1'b0);
        stat(`CTS_DTL_NO_BATT, `CTS_THM_REMOVED);
        zone(3'h6);
        chk(chgEn, 1'b1);
        stat(`CTS_DTL_CHARGING, `CTS_THM_GROUNDED);
    endtask
    task automatic t_fold();
        zone(3'h2);
        apb(1'b0, `CTS_OFF_EVENT, 32'h0);
        die <= 1'b1;
        cyc(6);
        chk({cur, irq}, {CUR - FOLD, 1'b1});
        apb(1'b0, `CTS_OFF_STATUS, 32'h0);
        chk({q[9:8], q[3:0]}, {2'b11, `CTS_DTL_CHARGING});
        apb(1'b0, `CTS_OFF_EVENT, 32'h0);
        die <= 1'b0;
        cyc(6);
        apb(1'b0, `CTS_OFF_EVENT, 32'h0);
        chk({q[0], cur}, {1'b1, CUR});
    endtask
    task automatic t_ship();
        apb(1'b1, `CTS_OFF_CNFG7, 32'h1);
        apb(1'b0, `CTS_OFF_CNFG7, 32'h0);
        chk({q[0], ship}, 2'b00);
        for (int i = 0; i < 4; i++) begin
            chgValid <= 1'b0;
            apb(1'b1, `CTS_OFF_CTRL, (i == 3) ? 32'hd : 32'h9);
            apb(1'b1, `CTS_OFF_CNFG7, 32'h1);
            chk(ship, 1'b1);
            if (i == 0 || i == 3) begin
                push(i ? 8 : 3);
                chk(ship, 1'b1);
                push(i ? 18 : 8);
            end
            chgValid <= (i == 1);
            if (i == 2)
                tempSel <= 3'h5;
            cyc(6);
            chk(ship, 1'b0);
            zone(3'h2);
        end
    endtask
    task automatic t_switch();
        logic [3:0] m;
        apb(1'b1, `CTS_OFF_CNFG7, 32'h2); // Overcurrent field 0
        for (int i = 0; i < 5; i++) begin
            m = (i == 2) ? `CTS_MODE_BOOST : 4'h4;
            m = (i == 3) ? `CTS_MODE_BOOST_OTG : m;
            {chgValid, buck} <= (i == 0) ? 2'b01 : (i == 1) ? 2'b11 : 2'b10;
            apb(1'b1, `CTS_OFF_CTRL, {20'h0, m, 8'h09});
            chk({swOut, swOe}, {1'b0, i == 0 || i == 4});
        end
        apb(1'b1, `CTS_OFF_CNFG7, 32'h0);
        chk(swOe, 1'b0);
    endtask

    task automatic wrap_up();
        $display("checks %0d, n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Reset, scenarios and verdict; watchdog beside
    initial begin
        {rst_n, psel, penable, pwrite, die, buck, button} = '0;
        chgValid = 1'b1;
        paddr = '0;
        pwdata = '0;
        tempSel = 3'h2;
        cyc(8);
        rst_n <= 1'b1;
        cyc(1);
        t_regs();
        t_zones();
        t_prof_off();
        t_batt();
        t_fold();
        t_ship();
        t_switch();
        wrap_up();
    end
    initial begin
        cyc(20000);
        n_fail++;
        wrap_up();
    end
endmodule
